/* File: include/banked_sram_pkg.sv */
// Shared widths, reset values and state layout for the banked dual-port memory.
// Assumes a single clock domain for both ports and no register bus.
package banked_sram_pkg;

    localparam int PORTS = 2;
    localparam int BANK_W = 6;
    localparam int WORD_W = 12;
    localparam int ADDR_W = BANK_W + WORD_W;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int DATA_W = LANE_W * LANES;
    localparam int BANKS = 64;
    localparam int WORDS_PER_BANK = 4096;
    localparam int DEPTH = BANKS * WORDS_PER_BANK;

    // Selected edges needed before read data may be trusted
    localparam int WARMUP_EDGES = 2;

    localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h00001;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [LANES-1:0] LANES_OFF = 2'h0;

    typedef enum logic [1:0]
    {
        ADDR_EXTERNAL = 2'b00,
        ADDR_REPEAT = 2'b01,
        ADDR_ADVANCE = 2'b10,
        ADDR_HOLD = 2'b11
    } addr_src_t;

    typedef struct packed
    {
        logic [ADDR_W-1:0] counter;
        logic [ADDR_W-1:0] loaded;
        logic [DATA_W-1:0] stage;
        logic [LANES-1:0] stageDrive;
        logic [DATA_W-1:0] dout;
        logic [LANES-1:0] drive;
        logic selPrev;
        logic powerDown;
    } port_state_t;

    typedef struct packed
    {
        port_state_t [PORTS-1:0] port;
        logic clash;
    } state_t;

    localparam port_state_t PORT_RST = '{
        counter: ADDR_RST,
        loaded: ADDR_RST,
        stage: DATA_RST,
        stageDrive: LANES_OFF,
        dout: DATA_RST,
        drive: LANES_OFF,
        selPrev: 1'b0,
        powerDown: 1'b1
    };

endpackage : banked_sram_pkg

/* File: verilog/banked_dual_port_sync_sram_port.sv */
// Two-port synchronous memory of 64 banks by 4K words by 18 bits, with burst
// counters, byte lanes, pipelined or flow-through read data and async output enable.
// Assumes both ports share mclk, all inputs are synchronous to it, and the masters
// keep to separate banks; the data pins are resolved outside from the enables.
//
// How it works
// - Array of 64 banks, 4K words of 18 bits, picked by bank and word address.
// - Both ports work at once and independently while their banks differ.
// - All inputs sampled at the rising edge except the asynchronous output enable.
// - Address strobe low loads the external bank and word address that cycle.
// - Access address is external with strobe low, else the last strobed one with repeat low, else the burst counter.
// - Advance low with strobe and repeat high steps the address; a write uses the stepped one.
// - Strobe, repeat and advance all high hold the address and the read data.
// - Counter spans bank and word; FFFh rolls into next bank, bank 63 to 0.
// - Repeat reloads the last strobed address with no dead cycle and accesses it.
// - Pipelined read data comes one cycle after flow-through read data.
// - Deselect or byte enables high float the outputs after the next edge, or after two edges when pipelined.
// - A byte enable high on a read floats only that lane of the data.
// - Pin state in turnarounds follows the controls sampled the cycle before.
// - Cross-port write then read needs the least offset; then new data appears.
// - Either chip enable inactive for a cycle powers down that port alone.
// - Two selected cycles are needed before read data is driven.
`timescale 1ns/1ps

module banked_dual_port_sync_sram_port
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [banked_sram_pkg::WORD_W-1:0] wordAddrLeft,
    input wire logic [banked_sram_pkg::BANK_W-1:0] bankSelectLeft,
    input wire logic addressStrobeNLeft,
    input wire logic counterAdvanceNLeft,
    input wire logic repeatNLeft,
    input wire logic chipSelectActiveLowNLeft,
    input wire logic chipSelectActiveHighLeft,
    input wire logic readWriteNLeft,
    input wire logic [banked_sram_pkg::LANES-1:0] byteLaneEnableNLeft,
    input wire logic outputEnableNLeft,
    input wire logic outputPipelineSelectLeft,
    input wire logic [banked_sram_pkg::DATA_W-1:0] dataInLeft,
    output logic [banked_sram_pkg::DATA_W-1:0] dataOutLeft,
    output logic [banked_sram_pkg::LANES-1:0] dataOeNLeft,
    output logic powerDownLeft,
    input wire logic [banked_sram_pkg::WORD_W-1:0] wordAddrRight,
    input wire logic [banked_sram_pkg::BANK_W-1:0] bankSelectRight,
    input wire logic addressStrobeNRight,
    input wire logic counterAdvanceNRight,
    input wire logic repeatNRight,
    input wire logic chipSelectActiveLowNRight,
    input wire logic chipSelectActiveHighRight,
    input wire logic readWriteNRight,
    input wire logic [banked_sram_pkg::LANES-1:0] byteLaneEnableNRight,
    input wire logic outputEnableNRight,
    input wire logic outputPipelineSelectRight,
    input wire logic [banked_sram_pkg::DATA_W-1:0] dataInRight,
    output logic [banked_sram_pkg::DATA_W-1:0] dataOutRight,
    output logic [banked_sram_pkg::LANES-1:0] dataOeNRight,
    output logic powerDownRight,
    output logic bankClash
);

    localparam int P = banked_sram_pkg::PORTS;
    localparam int AW = banked_sram_pkg::ADDR_W;
    localparam int DW = banked_sram_pkg::DATA_W;
    localparam int LN = banked_sram_pkg::LANES;
    localparam int LW = banked_sram_pkg::LANE_W;
    localparam int BW = banked_sram_pkg::BANK_W;
    localparam int WW = banked_sram_pkg::WORD_W;

    // Bank in the high bits, word in the low bits, so one flat index serves both
    logic [DW-1:0] mem [banked_sram_pkg::DEPTH];

    banked_sram_pkg::state_t state_q;
    banked_sram_pkg::state_t state_d;

    logic [WW-1:0] wordAddr [P];
    logic [BW-1:0] bankSel [P];
    logic [P-1:0] strobeN;
    logic [P-1:0] advanceN;
    logic [P-1:0] repeatN;
    logic [P-1:0] selLowN;
    logic [P-1:0] selHigh;
    logic [P-1:0] rdWrN;
    logic [LN-1:0] laneEnN [P];
    logic [P-1:0] oeN;
    logic [P-1:0] pipeMode;
    logic [DW-1:0] dataIn [P];

    logic [AW-1:0] accAddr [P];
    logic [P-1:0] selected;
    logic [P-1:0] doWrite;
    logic [DW-1:0] readWord [P];

    function automatic banked_sram_pkg::addr_src_t addrSource(
        input logic stbN,
        input logic rptN,
        input logic advN
    );
        if (!stbN)
        begin
            return banked_sram_pkg::ADDR_EXTERNAL;
        end
        else if (!rptN)
        begin
            return banked_sram_pkg::ADDR_REPEAT;
        end
        else if (!advN)
        begin
            return banked_sram_pkg::ADDR_ADVANCE;
        end
        return banked_sram_pkg::ADDR_HOLD;
    endfunction : addrSource

    // Lanes that will drive for a selected read; a disabled byte lane stays floating
    function automatic logic [LN-1:0] readLanes(
        input logic sel,
        input logic rd,
        input logic [LN-1:0] enN
    );
        return (sel && rd) ? ~enN : '0;
    endfunction : readLanes

    assign wordAddr[0] = wordAddrLeft;
    assign wordAddr[1] = wordAddrRight;
    assign bankSel[0] = bankSelectLeft;
    assign bankSel[1] = bankSelectRight;
    assign strobeN = {addressStrobeNRight, addressStrobeNLeft};
    assign advanceN = {counterAdvanceNRight, counterAdvanceNLeft};
    assign repeatN = {repeatNRight, repeatNLeft};
    assign selLowN = {chipSelectActiveLowNRight, chipSelectActiveLowNLeft};
    assign selHigh = {chipSelectActiveHighRight, chipSelectActiveHighLeft};
    assign rdWrN = {readWriteNRight, readWriteNLeft};
    assign laneEnN[0] = byteLaneEnableNLeft;
    assign laneEnN[1] = byteLaneEnableNRight;
    assign oeN = {outputEnableNRight, outputEnableNLeft};
    assign pipeMode = {outputPipelineSelectRight, outputPipelineSelectLeft};
    assign dataIn[0] = dataInLeft;
    assign dataIn[1] = dataInRight;

    always_comb
    begin
        state_d = state_q;
        for (int i = 0; i < P; i++)
        begin
            selected[i] = !selLowN[i] && selHigh[i];
            doWrite[i] = selected[i] && !rdWrN[i];
            accAddr[i] = state_q.port[i].counter;
            case (addrSource(strobeN[i], repeatN[i], advanceN[i]))
                banked_sram_pkg::ADDR_EXTERNAL:
                begin
                    accAddr[i] = {bankSel[i], wordAddr[i]};
                    state_d.port[i].loaded = accAddr[i];
                end
                banked_sram_pkg::ADDR_REPEAT:
                begin
                    accAddr[i] = state_q.port[i].loaded;
                end
                banked_sram_pkg::ADDR_ADVANCE:
                begin
                    // Natural roll of the flat address carries word into bank
                    accAddr[i] = state_q.port[i].counter + banked_sram_pkg::ADDR_ONE;
                end
                default:
                begin
                    accAddr[i] = state_q.port[i].counter;
                end
            endcase
            state_d.port[i].counter = accAddr[i];
            // Unconditional read; the latest write lands one edge later, giving
            // the opposite port new data on its next cycle
            readWord[i] = mem[accAddr[i]];

            // Power-down follows deselect; warm-up needs the previous edge selected too
            state_d.port[i].powerDown = !selected[i];
            state_d.port[i].selPrev = selected[i];
            state_d.port[i].stage = readWord[i];
            state_d.port[i].stageDrive = readLanes(
                selected[i] && state_q.port[i].selPrev, rdWrN[i], laneEnN[i]);
            if (pipeMode[i])
            begin
                // Extra register stage for pipelined mode
                state_d.port[i].dout = state_q.port[i].stage;
                state_d.port[i].drive = state_q.port[i].stageDrive;
            end
            else
            begin
                state_d.port[i].dout = readWord[i];
                state_d.port[i].drive = state_d.port[i].stageDrive;
            end
        end
        // Same bank on both ports is the masters' fault; only reported here
        state_d.clash = selected[0] && selected[1]
            && (accAddr[0][AW-1:WW] == accAddr[1][AW-1:WW]);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < P; i++)
            begin
                state_q.port[i] <= banked_sram_pkg::PORT_RST;
            end
            state_q.clash <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // No reset on the array: contents are undefined at power-up, as in any SRAM.
    // Right port is written after left, so on a same-word clash the right wins;
    // that case is invalid anyway.
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < P; i++)
        begin
            for (int b = 0; b < LN; b++)
            begin
                if (doWrite[i] && !laneEnN[i][b])
                begin
                    mem[accAddr[i]][b*LW +: LW] <= dataIn[i][b*LW +: LW];
                end
            end
        end
    end

    // Output enable works around the clock, straight onto the lane drivers
    assign dataOeNLeft = {LN{oeN[0]}} | ~state_q.port[0].drive;
    assign dataOeNRight = {LN{oeN[1]}} | ~state_q.port[1].drive;
    assign dataOutLeft = state_q.port[0].dout;
    assign dataOutRight = state_q.port[1].dout;
    assign powerDownLeft = state_q.port[0].powerDown;
    assign powerDownRight = state_q.port[1].powerDown;
    assign bankClash = state_q.clash;

endmodule : banked_dual_port_sync_sram_port

/* File: tb/sram_port_asserts.sv */
// Pin timing checks for the left port and the shared bank clash flag.
// Assumes one clock for both ports and a synchronous active-low reset.
`timescale 1ns/1ps

module sram_port_asserts
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic chipSelectActiveLowNLeft,
    input wire logic chipSelectActiveHighLeft,
    input wire logic readWriteNLeft,
    input wire logic [1:0] byteLaneEnableNLeft,
    input wire logic outputEnableNLeft,
    input wire logic outputPipelineSelectLeft,
    input wire logic [1:0] dataOeNLeft,
    input wire logic powerDownLeft,
    input wire logic [5:0] bankSelectLeft,
    input wire logic addressStrobeNLeft,
    input wire logic addressStrobeNRight,
    input wire logic chipSelectActiveLowNRight,
    input wire logic chipSelectActiveHighRight,
    input wire logic [5:0] bankSelectRight,
    input wire logic bankClash
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    wire selL = !chipSelectActiveLowNLeft && chipSelectActiveHighLeft;
    wire selR = !chipSelectActiveLowNRight && chipSelectActiveHighRight;
    wire pipe = outputPipelineSelectLeft;
    wire idle = !selL || !readWriteNLeft;
    wire rdAll = selL && readWriteNLeft && byteLaneEnableNLeft == 2'b00;

    pwr_down_a: assert property (!selL |=> powerDownLeft)
        else $error("port not powered down after deselect");
    flow_float_a: assert property (idle && !pipe |=> dataOeNLeft == 2'b11)
        else $error("flow lanes driven after idle edge");
    pipe_float_a: assert property (idle && pipe |-> ##2 dataOeNLeft == 2'b11)
        else $error("pipelined lanes driven after idle edge");
    oe_async_a: assert property (outputEnableNLeft |-> dataOeNLeft == 2'b11)
        else $error("lanes driven with output enable high");
    lane_float_a: assert property (byteLaneEnableNLeft[1] && !pipe |=> dataOeNLeft[1])
        else $error("disabled upper lane driven");
    warmup_float_a: assert property ($rose(selL) && !pipe |=> dataOeNLeft == 2'b11)
        else $error("data driven on first selected edge");
    // Bank pins name the accessed bank only on strobed edges; counter edges are not visible here
    clash_flag_a: assert property ($past(!addressStrobeNLeft && !addressStrobeNRight)
        |-> bankClash == $past(selL && selR && bankSelectLeft == bankSelectRight))
        else $error("bank clash flag wrong");
    flow_drive_a: assert property (selL ##1 rdAll && !pipe
        |=> outputEnableNLeft || dataOeNLeft == 2'b00) else $error("flow read not driven");
    pipe_drive_a: assert property (selL ##1 rdAll && pipe ##1 selL && readWriteNLeft
        |=> outputEnableNLeft || dataOeNLeft == 2'b00) else $error("pipelined read not driven");
endmodule : sram_port_asserts

bind banked_dual_port_sync_sram_port sram_port_asserts u_chk (.*);

/* File: tb/sram_far_master.sv */
// Right-port master: writes one word while farGo is high, released otherwise.
// Assumes farGo and its fields change just after a rising mclk edge.
`timescale 1ns/1ps

module sram_far_master
(
    input wire logic farGo,
    input wire logic [5:0] farBank,
    input wire logic [11:0] farWord,
    input wire logic [17:0] farData,
    output logic [11:0] wordAddrRight,
    output logic [5:0] bankSelectRight,
    output logic addressStrobeNRight,
    output logic counterAdvanceNRight,
    output logic repeatNRight,
    output logic chipSelectActiveLowNRight,
    output logic chipSelectActiveHighRight,
    output logic readWriteNRight,
    output logic [1:0] byteLaneEnableNRight,
    output logic outputEnableNRight,
    output logic outputPipelineSelectRight,
    output logic [17:0] dataInRight
);
    // Released lines flip so a stale value never looks valid
    assign bankSelectRight = farGo ? farBank : ~farBank;
    assign wordAddrRight = farGo ? farWord : ~farWord;
    assign dataInRight = farGo ? farData : ~farData;
    assign addressStrobeNRight = 1'b0;
    assign counterAdvanceNRight = 1'b1;
    assign repeatNRight = 1'b1;
    assign chipSelectActiveLowNRight = !farGo;
    assign chipSelectActiveHighRight = 1'b1;
    assign readWriteNRight = !farGo;
    assign byteLaneEnableNRight = 2'b00;
    assign outputEnableNRight = 1'b1;
    assign outputPipelineSelectRight = 1'b1;
endmodule : sram_far_master

/* File: tb/banked_dual_port_sync_sram_port_tb.sv */
// Self-checking bench: left port driven here, right port by the far master.
// Assumes inputs sampled on rising mclk; they change 1 ns after it.
`timescale 1ns/1ps

module banked_dual_port_sync_sram_port_tb;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic farGo = 1'b0;
    logic [11:0] wordAddrLeft, wordAddrRight, farWord, wa;
    logic [5:0] bankSelectLeft, bankSelectRight, farBank;
    logic addressStrobeNLeft, counterAdvanceNLeft, repeatNLeft, chipSelectActiveLowNLeft;
    logic chipSelectActiveHighLeft, readWriteNLeft, outputEnableNLeft, outputPipelineSelectLeft;
    logic addressStrobeNRight, counterAdvanceNRight, repeatNRight, chipSelectActiveLowNRight;
    logic chipSelectActiveHighRight, readWriteNRight, outputEnableNRight, outputPipelineSelectRight;
    logic [1:0] byteLaneEnableNLeft, byteLaneEnableNRight, dataOeNLeft, dataOeNRight;
    logic [17:0] dataInLeft, dataInRight, dataOutLeft, dataOutRight, farData, aA;
    logic [17:0] dA, dE, dF, dG, dH;
    logic powerDownLeft, powerDownRight, bankClash;
    logic [20:0] note;
    logic [20:0] nQ[$];
    int atQ[$];
    int cyc = 0;
    int lat = 0;
    int fails = 0;
    int compares = 0;
    integer seed = 32'hac01;

    banked_dual_port_sync_sram_port u_dut (.*);
    sram_far_master u_far (.*);

    always #10 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // n: push flag, full compare flag, lane enables, data
    task automatic set(input logic [4:0] c, input logic [1:0] ln, input logic [17:0] a,
        input logic [17:0] d, input logic [21:0] n);
        {addressStrobeNLeft, counterAdvanceNLeft, repeatNLeft, chipSelectActiveLowNLeft,
            readWriteNLeft} = c;
        byteLaneEnableNLeft = ln;
        {bankSelectLeft, wordAddrLeft} = a;
        dataInLeft = d;
        if (n[21])
        begin
            atQ.push_back(cyc + 1 + lat);
            nQ.push_back(n[20:0]);
        end
    endtask : set

    task automatic drv(input logic [4:0] c, input logic [1:0] ln, input logic [17:0] a,
        input logic [17:0] d, input logic [21:0] n);
        @(posedge mclk);
        #1;
        set(c, ln, a, d, n);
    endtask : drv

    always @(negedge mclk)
    begin
        if (atQ.size() > 0 && atQ[0] == cyc)
        begin
            void'(atQ.pop_front());
            note = nQ.pop_front();
            if (note[20])
                check({dataOeNLeft, dataOutLeft}, note[19:0]);
            else
                check({dataOeNLeft, 18'h0}, {note[19:18], 18'h0});
        end
    end

    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end

    initial
    begin
        chipSelectActiveHighLeft = 1'b1;
        outputEnableNLeft = 1'b0;
        farBank = 6'h09;
        farWord = 12'h0;
        farData = 18'h0;
        for (int m = 0; m < 2; m++)
        begin
            lat = m;
            rst_b = 1'b0;
            outputPipelineSelectLeft = m[0];
            set(5'h1f, 2'b11, 18'h0, 18'h0, 22'h0);
            repeat (8) @(posedge mclk);
            #1;
            rst_b = 1'b1;
            wa = 12'($random(seed));
            dA = 18'($random(seed));
            dE = 18'($random(seed));
            dF = 18'($random(seed));
            dG = 18'($random(seed));
            dH = 18'($random(seed));
            aA = {6'h05, wa};
            drv(5'h0c, 2'b00, aA, dA, 22'h0);
            drv(5'h0c, 2'b00, 18'h3ffff, dE, 22'h0);
            drv(5'h0c, 2'b00, 18'h00000, dF, 22'h0);
            drv(5'h0d, 2'b00, aA, 18'h0, {4'hc, dA});
            drv(5'h0d, 2'b00, 18'h3ffff, 18'h0, {4'hc, dE});
            drv(5'h15, 2'b00, aA, 18'h0, {4'hc, dF});
            drv(5'h1d, 2'b00, aA, 18'h0, {4'hc, dF});
            drv(5'h19, 2'b00, aA, 18'h0, {4'hc, dE});
            drv(5'h0d, 2'b10, aA, 18'h0, {4'he, dA});
            drv(5'h0c, 2'b01, aA, dG, 22'h0);
            drv(5'h0d, 2'b00, aA, 18'h0, {4'hc, dG[17:9], dA[8:0]});
            drv(5'h1f, 2'b00, aA, 18'h0, {4'hb, 18'h0});
            drv(5'h0d, 2'b00, aA, 18'h0, {4'hb, 18'h0});
            drv(5'h0c, 2'b00, aA, {dG[17:9], dA[8:0]}, 22'h0);
            drv(5'h14, 2'b00, 18'h3ffff, dH, 22'h0);
            drv(5'h0d, 2'b00, aA + 18'h1, 18'h0, {4'hc, dH});
            drv(5'h0d, 2'b00, aA, 18'h0, {4'hc, dG[17:9], dA[8:0]});
            farWord = 12'($random(seed));
            farData = 18'($random(seed));
            farGo = 1'b1;
            drv(5'h0d, 2'b00, {farBank, farWord}, 18'h0, {4'hc, farData});
            // Far side stays on the same bank one more edge to raise the clash flag
            @(posedge mclk);
            #1;
            check({19'h0, bankClash}, 20'h00001);
            farGo = 1'b0;
            repeat (3) @(negedge mclk);
            #2;
            outputEnableNLeft = 1'b1;
            #2;
            check({dataOeNLeft, 18'h0}, 20'hc0000);
            @(posedge mclk);
            #1;
            outputEnableNLeft = 1'b0;
        end
        give_verdict();
    end
endmodule : banked_dual_port_sync_sram_port_tb
